// ==== pkg/timer16_pkg.sv ====
// Constants, field layouts and types shared by the 16-bit timer design.
// Assumes a byte-addressed Avalon-MM bus with one 32-bit word per register.
package timer16_pkg;
  localparam int ADDR_W = 10;
  // Register indices; each register's byte address is four times its index.
  localparam logic [7:0] IDX_CTRL_A = 8'h80;
  localparam logic [7:0] IDX_CTRL_B = 8'h81;
  localparam logic [7:0] IDX_COUNT = 8'h84;
  localparam logic [7:0] IDX_CAPTURE = 8'h86;
  localparam logic [7:0] IDX_CMP_A = 8'h88;
  localparam logic [7:0] IDX_CMP_B = 8'h8A;
  localparam logic [7:0] IDX_STATUS = 8'h90;
  localparam logic [7:0] IDX_MASK = 8'h91;
  localparam logic [7:0] IDX_PIN_DIR = 8'h92;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_A = {IDX_CTRL_A, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CTRL_B = {IDX_CTRL_B, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_COUNT = {IDX_COUNT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CAPTURE = {IDX_CAPTURE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CMP_A = {IDX_CMP_A, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CMP_B = {IDX_CMP_B, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MASK = {IDX_MASK, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PIN_DIR = {IDX_PIN_DIR, 2'b00};
  // Reset values and writable-bit masks of the control registers.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_MASK = 8'hF3;
  localparam logic [7:0] CTRL_B_MASK = 8'hDF;
  // Field positions.
  localparam int CHAN_A_MODE_LSB = 6;
  localparam int CHAN_B_MODE_LSB = 4;
  localparam int WAVE_LO_LSB = 0;
  localparam int FILTER_EN_BIT = 7;
  localparam int EDGE_SEL_BIT = 6;
  localparam int WAVE_HI_LSB = 3;
  localparam int CLK_SEL_LSB = 0;
  // Status and mask bit positions.
  localparam int ST_OVERFLOW = 0;
  localparam int ST_MATCH_A = 1;
  localparam int ST_MATCH_B = 2;
  localparam int ST_CAPTURE = 3;
  localparam int ST_W = 4;
  // Counting limits.
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam int FILTER_SAMPLES = 4;
  // Waveform-mode codes that act individually.
  localparam logic [3:0] WM_NORMAL = 4'h0;
  localparam logic [3:0] WM_PC8 = 4'h1;
  localparam logic [3:0] WM_PC9 = 4'h2;
  localparam logic [3:0] WM_PC10 = 4'h3;
  localparam logic [3:0] WM_CTC_CMP = 4'h4;
  localparam logic [3:0] WM_FAST8 = 4'h5;
  localparam logic [3:0] WM_FAST9 = 4'h6;
  localparam logic [3:0] WM_FAST10 = 4'h7;
  localparam logic [3:0] WM_PFC_CAP = 4'h8;
  localparam logic [3:0] WM_PFC_CMP = 4'h9;
  localparam logic [3:0] WM_PC_CAP = 4'hA;
  localparam logic [3:0] WM_PC_CMP = 4'hB;
  localparam logic [3:0] WM_CTC_CAP = 4'hC;
  localparam logic [3:0] WM_RESERVED = 4'hD;
  localparam logic [3:0] WM_FAST_CAP = 4'hE;
  localparam logic [3:0] WM_FAST_CMP = 4'hF;
  // Clock-select codes.
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // Output-mode codes.
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;

  typedef enum logic [2:0] {K_NORMAL, K_CTC, K_FAST, K_PC, K_PFC} kind_t;
endpackage

// ==== pkg/capture_if.sv ====
// Link between the timer core and its capture front end.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface capture_if;
  logic filter_en;
  logic edge_sel;
  logic enable;
  logic event_pulse;
  modport core (output filter_en, output edge_sel, output enable, input event_pulse);
  modport front (input filter_en, input edge_sel, input enable, output event_pulse);
endinterface
`default_nettype wire

// ==== hw/capture_front.sv ====
// Capture pin noise filter and edge detector.
// Assumes the capture pin is already synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module capture_front (
  input wire logic clock,
  input wire logic srst,
  input wire logic capture_pin,
  capture_if.front cap
);
  logic [timer16_pkg::FILTER_SAMPLES-1:0] sample_reg;
  logic filtered_reg;
  logic prev_reg;
  logic event_reg;
  logic all_high;
  logic all_low;
  logic filtered_next;
  logic edge_hit;

  assign all_high = &sample_reg;
  assign all_low = ~|sample_reg;
  // The filtered level moves only after four equal samples when filtering.
  assign filtered_next = !cap.filter_en ? sample_reg[0] :
    all_high ? 1'b1 : all_low ? 1'b0 : filtered_reg;
  assign edge_hit = cap.edge_sel ? (filtered_reg & ~prev_reg) :
    (~filtered_reg & prev_reg);
  assign cap.event_pulse = event_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      sample_reg <= '0;
      filtered_reg <= 1'b0;
      prev_reg <= 1'b0;
      event_reg <= 1'b0;
    end else begin
      sample_reg <= {sample_reg[timer16_pkg::FILTER_SAMPLES-2:0], capture_pin};
      filtered_reg <= filtered_next;
      prev_reg <= filtered_reg;
      event_reg <= edge_hit & cap.enable;
    end
  end
endmodule
`default_nettype wire

// ==== hw/timer16_ctrl.sv ====
// 16-bit timer with mode and capture control registers on an Avalon-MM slave.
// Assumes all pins are synchronous to clock and a single-clock system.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module timer16_ctrl (
  input wire logic clock,
  input wire logic srst,
  input wire logic [timer16_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic capture_pin,
  input wire logic external_count_pin,
  output logic compare_out_a,
  output logic compare_out_a_oe,
  output logic compare_out_b,
  output logic compare_out_b_oe,
  output logic irq
);
  function automatic timer16_pkg::kind_t mode_kind(input logic [3:0] w);
    unique case (w)
      timer16_pkg::WM_CTC_CMP, timer16_pkg::WM_CTC_CAP: mode_kind = timer16_pkg::K_CTC;
      timer16_pkg::WM_PC8, timer16_pkg::WM_PC9, timer16_pkg::WM_PC10,
      timer16_pkg::WM_PC_CAP, timer16_pkg::WM_PC_CMP: mode_kind = timer16_pkg::K_PC;
      timer16_pkg::WM_FAST8, timer16_pkg::WM_FAST9, timer16_pkg::WM_FAST10,
      timer16_pkg::WM_FAST_CAP, timer16_pkg::WM_FAST_CMP: mode_kind = timer16_pkg::K_FAST;
      timer16_pkg::WM_PFC_CAP, timer16_pkg::WM_PFC_CMP: mode_kind = timer16_pkg::K_PFC;
      default: mode_kind = timer16_pkg::K_NORMAL;
    endcase
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] w, input logic [15:0] cmp_a,
                                         input logic [15:0] cap);
    unique case (w)
      timer16_pkg::WM_PC8, timer16_pkg::WM_FAST8: top_of = timer16_pkg::TOP_8BIT;
      timer16_pkg::WM_PC9, timer16_pkg::WM_FAST9: top_of = timer16_pkg::TOP_9BIT;
      timer16_pkg::WM_PC10, timer16_pkg::WM_FAST10: top_of = timer16_pkg::TOP_10BIT;
      timer16_pkg::WM_CTC_CMP, timer16_pkg::WM_PFC_CMP, timer16_pkg::WM_PC_CMP,
      timer16_pkg::WM_FAST_CMP: top_of = cmp_a;
      timer16_pkg::WM_PFC_CAP, timer16_pkg::WM_PC_CAP, timer16_pkg::WM_CTC_CAP,
      timer16_pkg::WM_FAST_CAP: top_of = cap;
      default: top_of = timer16_pkg::CNT_MAX;
    endcase
  endfunction

  function automatic logic uses_cap_top(input logic [3:0] w);
    uses_cap_top = (w == timer16_pkg::WM_PFC_CAP) || (w == timer16_pkg::WM_PC_CAP) ||
                   (w == timer16_pkg::WM_CTC_CAP) || (w == timer16_pkg::WM_FAST_CAP);
  endfunction

  // True when output mode 1 may toggle channel A in the given PWM mode.
  function automatic logic toggle_ok(input timer16_pkg::kind_t k, input logic [3:0] w);
    if (k == timer16_pkg::K_FAST) begin
      toggle_ok = (w == timer16_pkg::WM_FAST_CAP) || (w == timer16_pkg::WM_FAST_CMP);
    end else begin
      toggle_ok = (w == timer16_pkg::WM_PFC_CMP) || (w == timer16_pkg::WM_PC_CMP);
    end
  endfunction

  function automatic logic is_pwm(input timer16_pkg::kind_t k);
    is_pwm = (k == timer16_pkg::K_FAST) || (k == timer16_pkg::K_PC) || (k == timer16_pkg::K_PFC);
  endfunction

  // Next level of one compare output.
  function automatic logic wave_next(input timer16_pkg::kind_t k, input logic [1:0] m,
                                     input logic may_toggle, input logic cur, input logic hit,
                                     input logic wrap, input logic up, input logic cmp_top);
    logic inv;
    inv = (m == timer16_pkg::OM_SET);
    wave_next = cur;
    if (!is_pwm(k)) begin
      if (hit) begin
        unique case (m)
          timer16_pkg::OM_TOGGLE: wave_next = ~cur;
          timer16_pkg::OM_CLEAR: wave_next = 1'b0;
          timer16_pkg::OM_SET: wave_next = 1'b1;
          default: wave_next = cur;
        endcase
      end
    end else if (m == timer16_pkg::OM_TOGGLE) begin
      if (hit && may_toggle) begin
        wave_next = ~cur;
      end
    end else if (m[1]) begin
      if (k == timer16_pkg::K_FAST) begin
        if (wrap) begin
          wave_next = ~inv;
        end else if (hit && !cmp_top) begin
          wave_next = inv;
        end
      end else if (hit) begin
        wave_next = up ? inv : ~inv;
      end
    end
  endfunction

  // Writes only the byte lanes that are enabled.
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      lanes[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function automatic logic presc_tick(input logic [2:0] cs, input logic [9:0] pre,
                                      input logic ext_rise, input logic ext_fall);
    unique case (cs)
      timer16_pkg::CS_STOP: presc_tick = 1'b0;
      timer16_pkg::CS_DIV1: presc_tick = 1'b1;
      timer16_pkg::CS_DIV8: presc_tick = &pre[2:0];
      timer16_pkg::CS_DIV64: presc_tick = &pre[5:0];
      timer16_pkg::CS_DIV256: presc_tick = &pre[7:0];
      timer16_pkg::CS_DIV1024: presc_tick = &pre[9:0];
      timer16_pkg::CS_EXT_FALL: presc_tick = ext_fall;
      timer16_pkg::CS_EXT_RISE: presc_tick = ext_rise;
    endcase
  endfunction

  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic dir_up_reg;
  logic dir_up_next;
  logic [15:0] capture_reg;
  logic [15:0] cmp_a_buf_reg;
  logic [15:0] cmp_b_buf_reg;
  logic [15:0] cmp_a_reg;
  logic [15:0] cmp_b_reg;
  logic [timer16_pkg::ST_W-1:0] status_reg;
  logic [timer16_pkg::ST_W-1:0] mask_reg;
  logic [1:0] pin_dir_reg;
  logic [9:0] pre_reg;
  logic ext_prev_reg;
  logic block_reg;
  logic wave_a_reg;
  logic wave_b_reg;
  logic ack_reg;
  logic [31:0] readdata_reg;

  capture_if cap ();

  capture_front front (
    .clock(clock),
    .srst(srst),
    .capture_pin(capture_pin),
    .cap(cap)
  );

  // Register decode: one wait cycle, then the answer.
  logic access;
  logic wr_en;
  logic sel_ctrl_a;
  logic sel_ctrl_b;
  logic sel_count;
  logic sel_capture;
  logic sel_cmp_a;
  logic sel_cmp_b;
  logic sel_status;
  logic sel_mask;
  logic sel_pin_dir;
  logic [31:0] wmerged;
  logic [31:0] read_mux;

  assign access = read | write;
  assign waitrequest = access & ~ack_reg;
  assign wr_en = write & ack_reg;
  assign sel_ctrl_a = address == timer16_pkg::ADDR_CTRL_A;
  assign sel_ctrl_b = address == timer16_pkg::ADDR_CTRL_B;
  assign sel_count = address == timer16_pkg::ADDR_COUNT;
  assign sel_capture = address == timer16_pkg::ADDR_CAPTURE;
  assign sel_cmp_a = address == timer16_pkg::ADDR_CMP_A;
  assign sel_cmp_b = address == timer16_pkg::ADDR_CMP_B;
  assign sel_status = address == timer16_pkg::ADDR_STATUS;
  assign sel_mask = address == timer16_pkg::ADDR_MASK;
  assign sel_pin_dir = address == timer16_pkg::ADDR_PIN_DIR;
  assign wmerged = lanes(readdata_reg, writedata, byteenable);
  assign read_mux = sel_ctrl_a ? {24'h000000, ctrl_a_reg} :
                    sel_ctrl_b ? {24'h000000, ctrl_b_reg} :
                    sel_count ? {16'h0000, count_reg} :
                    sel_capture ? {16'h0000, capture_reg} :
                    sel_cmp_a ? {16'h0000, cmp_a_buf_reg} :
                    sel_cmp_b ? {16'h0000, cmp_b_buf_reg} :
                    sel_status ? {28'h0000000, status_reg} :
                    sel_mask ? {28'h0000000, mask_reg} :
                    sel_pin_dir ? {30'h00000000, pin_dir_reg} : 32'h00000000;
  assign readdata = readdata_reg;

  // Mode fields and derived timing.
  logic [3:0] wave_mode;
  logic [1:0] chan_a_output_mode;
  logic [1:0] chan_b_output_mode;
  logic [2:0] clk_sel;
  timer16_pkg::kind_t kind;
  logic [15:0] top;
  logic at_top;
  logic at_bottom;
  logic tick;
  logic ext_rise;
  logic ext_fall;
  logic overflow_ev;
  logic update_ev;
  logic wrap;
  logic hit_a;
  logic hit_b;
  logic capture_ev;
  logic conn_a;
  logic conn_b;
  logic [timer16_pkg::ST_W-1:0] events;
  logic [timer16_pkg::ST_W-1:0] clear_bits;

  assign wave_mode = {ctrl_b_reg[timer16_pkg::WAVE_HI_LSB +: 2],
                      ctrl_a_reg[timer16_pkg::WAVE_LO_LSB +: 2]};
  assign chan_a_output_mode = ctrl_a_reg[timer16_pkg::CHAN_A_MODE_LSB +: 2];
  assign chan_b_output_mode = ctrl_a_reg[timer16_pkg::CHAN_B_MODE_LSB +: 2];
  assign clk_sel = ctrl_b_reg[timer16_pkg::CLK_SEL_LSB +: 3];
  assign kind = mode_kind(wave_mode);
  assign top = top_of(wave_mode, cmp_a_reg, capture_reg);
  assign at_top = count_reg == top;
  assign at_bottom = count_reg == 16'h0000;
  assign ext_rise = external_count_pin & ~ext_prev_reg;
  assign ext_fall = ~external_count_pin & ext_prev_reg;
  assign tick = presc_tick(clk_sel, pre_reg, ext_rise, ext_fall);
  assign wrap = tick & (kind == timer16_pkg::K_FAST) & at_top;
  assign overflow_ev = tick & (((kind == timer16_pkg::K_NORMAL || kind == timer16_pkg::K_CTC) &&
                               count_reg == timer16_pkg::CNT_MAX) ||
                               (kind == timer16_pkg::K_FAST && at_top) ||
                               (kind inside {timer16_pkg::K_PC, timer16_pkg::K_PFC} &&
                                at_bottom && !dir_up_reg));
  assign update_ev = tick & ((kind == timer16_pkg::K_PC && at_top) ||
                             (kind == timer16_pkg::K_FAST && at_top) ||
                             (kind == timer16_pkg::K_PFC && at_bottom && !dir_up_reg));
  assign hit_a = tick & ~block_reg & (count_reg == cmp_a_reg);
  assign hit_b = tick & ~block_reg & (count_reg == cmp_b_reg);
  assign cap.filter_en = ctrl_b_reg[timer16_pkg::FILTER_EN_BIT];
  assign cap.edge_sel = ctrl_b_reg[timer16_pkg::EDGE_SEL_BIT];
  assign cap.enable = ~uses_cap_top(wave_mode);
  assign capture_ev = cap.event_pulse;
  assign events = {capture_ev, hit_b, hit_a, overflow_ev};
  // Clearing takes the written ones only; a disabled lane must not clear pending flags.
  assign clear_bits = (wr_en & sel_status & byteenable[0]) ? writedata[timer16_pkg::ST_W-1:0] : '0;

  // Mode 1 in a PWM mode connects channel A only where toggling is allowed.
  assign conn_a = (chan_a_output_mode != timer16_pkg::OM_OFF) &&
                  !(chan_a_output_mode == timer16_pkg::OM_TOGGLE && is_pwm(kind) &&
                    !toggle_ok(kind, wave_mode));
  assign conn_b = (chan_b_output_mode != timer16_pkg::OM_OFF) &&
                  !(chan_b_output_mode == timer16_pkg::OM_TOGGLE && is_pwm(kind));
  assign compare_out_a = wave_a_reg;
  assign compare_out_b = wave_b_reg;
  assign compare_out_a_oe = conn_a & pin_dir_reg[0];
  assign compare_out_b_oe = conn_b & pin_dir_reg[1];
  assign irq = |(status_reg & mask_reg);

  // Counting sequence for each mode family.
  always_comb begin
    count_next = count_reg;
    dir_up_next = dir_up_reg;
    if (tick) begin
      unique case (kind)
        timer16_pkg::K_NORMAL: count_next = count_reg + 16'h0001;
        timer16_pkg::K_CTC, timer16_pkg::K_FAST: count_next = at_top ? 16'h0000 :
                                                              count_reg + 16'h0001;
        timer16_pkg::K_PC, timer16_pkg::K_PFC: begin
          if (dir_up_reg) begin
            count_next = at_top ? count_reg - 16'h0001 : count_reg + 16'h0001;
            dir_up_next = ~at_top;
          end else begin
            count_next = at_bottom ? count_reg + 16'h0001 : count_reg - 16'h0001;
            dir_up_next = at_bottom;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= access & ~ack_reg;
      if (access && !ack_reg) begin
        readdata_reg <= read_mux;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_a_reg <= timer16_pkg::CTRL_RESET;
      ctrl_b_reg <= timer16_pkg::CTRL_RESET;
      mask_reg <= '0;
      pin_dir_reg <= 2'h0;
    end else if (wr_en) begin
      if (sel_ctrl_a) ctrl_a_reg <= wmerged[7:0] & timer16_pkg::CTRL_A_MASK;
      if (sel_ctrl_b) ctrl_b_reg <= wmerged[7:0] & timer16_pkg::CTRL_B_MASK;
      if (sel_mask) mask_reg <= wmerged[timer16_pkg::ST_W-1:0];
      if (sel_pin_dir) pin_dir_reg <= wmerged[1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      count_reg <= 16'h0000;
      dir_up_reg <= 1'b1;
      block_reg <= 1'b0;
      pre_reg <= 10'h000;
      ext_prev_reg <= 1'b0;
    end else begin
      pre_reg <= pre_reg + 10'h001;
      ext_prev_reg <= external_count_pin;
      // A software write to the counter suppresses the next timer tick's match.
      if (wr_en && sel_count) begin
        count_reg <= wmerged[15:0];
        block_reg <= 1'b1;
      end else begin
        count_reg <= count_next;
        dir_up_reg <= dir_up_next;
        if (tick) block_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cmp_a_buf_reg <= 16'h0000;
      cmp_b_buf_reg <= 16'h0000;
      cmp_a_reg <= 16'h0000;
      cmp_b_reg <= 16'h0000;
      capture_reg <= 16'h0000;
    end else begin
      if (wr_en && sel_cmp_a) cmp_a_buf_reg <= wmerged[15:0];
      if (wr_en && sel_cmp_b) cmp_b_buf_reg <= wmerged[15:0];
      if (!is_pwm(kind) || update_ev) begin
        cmp_a_reg <= cmp_a_buf_reg;
        cmp_b_reg <= cmp_b_buf_reg;
      end
      if (capture_ev) begin
        capture_reg <= count_reg;
      end else if (wr_en && sel_capture) begin
        capture_reg <= wmerged[15:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      status_reg <= '0;
      wave_a_reg <= 1'b0;
      wave_b_reg <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~clear_bits) | events;
      wave_a_reg <= wave_next(kind, chan_a_output_mode, toggle_ok(kind, wave_mode), wave_a_reg,
                              hit_a, wrap, dir_up_reg, cmp_a_reg == top);
      wave_b_reg <= wave_next(kind, chan_b_output_mode, 1'b0, wave_b_reg,
                              hit_b, wrap, dir_up_reg, cmp_b_reg == top);
    end
  end
endmodule
`default_nettype wire

// ==== verif/timer16_ctrl_assertions.sv ====
// Bus and register assertions for the 16-bit timer control block.
// Assumes a master that holds each request until waitrequest is low.
`timescale 1ns/1ps
`default_nettype none
module timer16_ctrl_checker (
  input wire logic clock,
  input wire logic srst,
  input wire logic [timer16_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic compare_out_a_oe,
  input wire logic irq
);
  logic [7:0] sh_a, sh_b;
  logic [3:0] sh_m;
  wire logic wr_done = write && !waitrequest && byteenable[0];
  wire logic rd_done = read && !waitrequest;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Shadow of the control and mask registers, built from completed writes.
  always_ff @(posedge clock) begin
    if (srst) begin
      sh_a <= 8'h00;
      sh_b <= 8'h00;
      sh_m <= 4'h0;
    end else if (wr_done) begin
      if (address == timer16_pkg::ADDR_CTRL_A) sh_a <= writedata[7:0] & timer16_pkg::CTRL_A_MASK;
      if (address == timer16_pkg::ADDR_CTRL_B) sh_b <= writedata[7:0] & timer16_pkg::CTRL_B_MASK;
      if (address == timer16_pkg::ADDR_MASK) sh_m <= writedata[3:0];
    end
  end
  first_wait_a: assert property ((read || write) && !$past(read || write) |-> waitrequest)
    else $error("request answered without a wait cycle");
  one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest held past one cycle");
  reset_quiet_a: assert property (disable iff (1'b0)
    srst |=> !irq && !compare_out_a_oe)
    else $error("outputs active after reset");
  oe_mode_a: assert property (compare_out_a_oe |-> sh_a[7:6] != 2'b00)
    else $error("channel A driven while disconnected");
  mask_zero_a: assert property (sh_m == 4'h0 |-> !irq)
    else $error("interrupt with all sources masked");
  ctrl_a_read_a: assert property (rd_done && address == timer16_pkg::ADDR_CTRL_A |->
    readdata == {24'h0, sh_a})
    else $error("control A readback wrong");
  ctrl_b_read_a: assert property (rd_done && address == timer16_pkg::ADDR_CTRL_B |->
    readdata == {24'h0, sh_b})
    else $error("control B readback wrong");
  unmapped_read_a: assert property (rd_done && address == 10'h000 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  cover property (compare_out_a_oe);
  cover property (irq);
  cover property (rd_done && address == timer16_pkg::ADDR_CAPTURE);
endmodule
bind timer16_ctrl timer16_ctrl_checker i_timer16_ctrl_checker (
  .clock(clock), .srst(srst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .compare_out_a_oe(compare_out_a_oe), .irq(irq)
);
`default_nettype wire

// ==== verif/pin_source.sv ====
// Far-side model: drives the capture pin and feeds channel A back to the count pin.
// Assumes the bench sets the capture level through set_level.
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  input wire logic clock,
  input wire logic compare_out_a,
  input wire logic compare_out_a_oe,
  output logic capture_pin,
  output logic external_count_pin
);
  // An undriven count pin is pulled high.
  assign external_count_pin = compare_out_a_oe ? compare_out_a : 1'b1;
  initial capture_pin = 1'b0;
  task automatic set_level(input logic v);
    @(posedge clock);
    capture_pin <= v;
  endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the timer control block over its Avalon-MM slave.
// Assumes one wait cycle per access, as the slave's note gives.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [9:0] A_CA = timer16_pkg::ADDR_CTRL_A;
  localparam logic [9:0] A_CB = timer16_pkg::ADDR_CTRL_B;
  localparam logic [9:0] A_ST = timer16_pkg::ADDR_STATUS;
  localparam logic [9:0] A_CAP = timer16_pkg::ADDR_CAPTURE;
  localparam logic [9:0] A_CNT = timer16_pkg::ADDR_COUNT;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest, capture_pin, external_count_pin, irq;
  logic compare_out_a, compare_out_a_oe, compare_out_b, compare_out_b_oe;
  int num_errors = 0;
  int check_count = 0;
  always #20 clock = ~clock;
  timer16_ctrl i_timer16_ctrl (.clock(clock), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .capture_pin(capture_pin),
    .external_count_pin(external_count_pin), .compare_out_a(compare_out_a),
    .compare_out_a_oe(compare_out_a_oe), .compare_out_b(compare_out_b),
    .compare_out_b_oe(compare_out_b_oe), .irq(irq));
  pin_source i_pin_source (.clock(clock), .compare_out_a(compare_out_a),
    .compare_out_a_oe(compare_out_a_oe), .capture_pin(capture_pin),
    .external_count_pin(external_count_pin));
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic access(input logic w, input logic [9:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    @(posedge clock);
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (n == 20) begin
      num_errors++;
      summarize();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    access(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    rd(A_CA, 32'h0);
    rd(A_CB, 32'h0);
    wr(A_CA, 32'hFF);
    rd(A_CA, 32'hF3);
    wr(A_CB, 32'hFF);
    rd(A_CB, 32'hDF);
    wr(A_CB, 32'h0);
    rd(10'h000, 32'h0);
    wr(timer16_pkg::ADDR_PIN_DIR, 32'h3);
    wr(A_CA, 32'h40);
    #1;
    check({30'h0, compare_out_a_oe, compare_out_b_oe}, 32'h2);
    wr(timer16_pkg::ADDR_CMP_A, 32'h3);
    wr(timer16_pkg::ADDR_CMP_B, 32'h2);
    // Clear-on-match mode at full rate, both channels set on match.
    wr(A_CA, 32'hF0);
    wr(A_CB, 32'h09);
    repeat (20) @(posedge clock);
    check({30'h0, compare_out_a, compare_out_b}, 32'h3);
    wr(A_CA, 32'hA0);
    repeat (20) @(posedge clock);
    check({30'h0, compare_out_a, compare_out_b}, 32'h0);
    wr(A_CB, 32'h08);
    rd(A_ST, 32'h6);
    wr(timer16_pkg::ADDR_MASK, 32'h2);
    #1;
    check({31'h0, irq}, 32'h1);
    // Writes with the low lane disabled must leave flags and controls alone.
    byteenable <= 4'hE;
    wr(A_ST, 32'hF);
    rd(A_ST, 32'h6);
    wr(A_CA, 32'h0);
    rd(A_CA, 32'hA0);
    byteenable <= 4'hF;
    wr(A_ST, 32'hF);
    rd(A_ST, 32'h0);
    #1;
    check({31'h0, irq}, 32'h0);
    // Fast PWM with an 8-bit top: matches and the overflow at top set flags.
    wr(A_CA, 32'hA1);
    wr(A_CB, 32'h09);
    repeat (300) @(posedge clock);
    wr(A_CB, 32'h08);
    rd(A_ST, 32'h7);
    wr(A_ST, 32'hF);
    wr(A_CA, 32'hA0);
    wr(A_CB, 32'h40);
    wr(A_CNT, 32'h1234);
    i_pin_source.set_level(1'b1);
    repeat (10) @(posedge clock);
    rd(A_CAP, 32'h1234);
    rd(A_ST, 32'h8);
    wr(A_CNT, 32'h5555);
    i_pin_source.set_level(1'b0);
    repeat (10) @(posedge clock);
    rd(A_CAP, 32'h1234);
    wr(A_CB, 32'h58);
    i_pin_source.set_level(1'b1);
    repeat (10) @(posedge clock);
    rd(A_CAP, 32'h1234);
    wr(A_CB, 32'h80);
    i_pin_source.set_level(1'b0);
    @(posedge clock);
    i_pin_source.set_level(1'b1);
    repeat (10) @(posedge clock);
    rd(A_CAP, 32'h1234);
    i_pin_source.set_level(1'b0);
    repeat (12) @(posedge clock);
    rd(A_CAP, 32'h5555);
    summarize();
  end
endmodule
`default_nettype wire
